// *** verilog/chb_defs.vh ***
`ifndef CHB_DEFS_VH
`define CHB_DEFS_VH
// ---------------------------------------------------------------
// Operating modes
// ---------------------------------------------------------------
`define CHB_MODE_MEM     2'h0
`define CHB_MODE_IO      2'h1
`define CHB_MODE_ATA     2'h2
// ---------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------
`define CHB_ADDR_W       11
`define CHB_TF_W         3
`define CHB_SPACE_COMMON 2'h0
`define CHB_SPACE_ATTR   2'h1
`define CHB_SPACE_IO     2'h2
`define CHB_SPACE_TF     2'h3
// ---------------------------------------------------------------
// Card configuration and status register bits
// ---------------------------------------------------------------
`define CHB_CSR_SIGCHG   4
`define CHB_CSR_CHANGED  5
// ---------------------------------------------------------------
// Edge detector settling after reset
// ---------------------------------------------------------------
`define CHB_SETTLE_DONE  2'h3
`endif

// *** verilog/chb_sync.v ***
`timescale 1ns/1ps
module chb_sync #(
    parameter W = 1
) (
    ref_clk,
    rst_n,
    din,
    dout
);
    input  wire         ref_clk;
    input  wire         rst_n;
    input  wire [W-1:0] din;
    output reg  [W-1:0] dout;

    reg [W-1:0] stage1;

    // ---------------------------------------------------------------
    // Two-stage synchroniser; stage1 feeds only dout.
    // ---------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// *** verilog/chb_host_bus.v ***
`timescale 1ns/1ps
`include "chb_defs.vh"
module chb_host_bus (
    ref_clk,
    rst_n,
    card_mode,
    addr,
    attr_sel_n,
    card_sel_n,
    io_read_n,
    card_ready,
    write_protect,
    alert_enable,
    alert_ack,
    status_change_pending,
    access_space,
    access_index,
    access_tf_reg,
    data_in,
    word_access,
    bus_data_out,
    input_acknowledge,
    battery_detect_one,
    battery_detect_two,
    battery_detect_one_oe_n,
    battery_detect_two_oe_n,
    diag_drive_low,
    active_drive_low,
    pass_diagnostic_line_in,
    drive_active_secondary_present_in,
    pass_diagnostic_seen,
    secondary_present_seen
);
    input  wire                   ref_clk;
    input  wire                   rst_n;
    input  wire [1:0]             card_mode;
    input  wire [`CHB_ADDR_W-1:0] addr;
    input  wire                   attr_sel_n;
    input  wire                   card_sel_n;
    input  wire                   io_read_n;
    input  wire                   card_ready;
    input  wire                   write_protect;
    input  wire                   alert_enable;
    input  wire                   alert_ack;
    output reg                    status_change_pending;
    output reg  [1:0]             access_space;
    output reg  [`CHB_ADDR_W-1:0] access_index;
    output reg  [`CHB_TF_W-1:0]   access_tf_reg;
    input  wire [15:0]            data_in;
    input  wire                   word_access;
    output reg  [15:0]            bus_data_out;
    output wire                   input_acknowledge;
    output wire                   battery_detect_one;
    output wire                   battery_detect_two;
    output wire                   battery_detect_one_oe_n;
    output wire                   battery_detect_two_oe_n;
    input  wire                   diag_drive_low;
    input  wire                   active_drive_low;
    input  wire                   pass_diagnostic_line_in;
    input  wire                   drive_active_secondary_present_in;
    output wire                   pass_diagnostic_seen;
    output wire                   secondary_present_seen;

    wire [`CHB_ADDR_W-1:0] s_addr;
    wire                   s_attr;
    wire                   s_sel;
    wire                   s_iord;
    wire                   s_ready;
    wire                   s_wp;
    wire                   s_diag_low;
    wire                   s_active_low;
    reg                    prev_ready;
    reg                    prev_wp;
    reg                    ack;
    reg                    mode_is_io;
    reg                    mode_is_mem;
    reg                    mode_is_ata;
    wire                   change;
    reg  [1:0]             settle;
    wire                   settled;

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    function mode_equals;
        input [1:0] mode;
        input [1:0] want;
        begin
            mode_equals = (mode == want);
        end
    endfunction

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    // Active-low pins are inverted on the way in, so a cleared synchroniser
    // reads as an idle pin and nothing looks asserted while the first
    // samples are still travelling through it.
    chb_sync #(.W(`CHB_ADDR_W + 7)) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     ({addr, ~attr_sel_n, ~card_sel_n, ~io_read_n, card_ready, write_protect,
                   ~pass_diagnostic_line_in, ~drive_active_secondary_present_in}),
        .dout    ({s_addr, s_attr, s_sel, s_iord, s_ready, s_wp, s_diag_low, s_active_low})
    );

    always @* begin
        mode_is_mem = mode_equals(card_mode, `CHB_MODE_MEM);
        mode_is_io  = mode_equals(card_mode, `CHB_MODE_IO);
        mode_is_ata = mode_equals(card_mode, `CHB_MODE_ATA);
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    // Upper lines are not looked at in ATA mode, so a host that fails to
    // ground them still reaches the right task-file register.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_space  <= `CHB_SPACE_COMMON;
            access_index  <= {`CHB_ADDR_W{1'b0}};
            access_tf_reg <= {`CHB_TF_W{1'b0}};
        end else if (mode_is_ata) begin
            access_space  <= `CHB_SPACE_TF;
            access_index  <= {`CHB_ADDR_W{1'b0}};
            access_tf_reg <= s_addr[`CHB_TF_W-1:0];
        end else begin
            access_index  <= s_addr;
            access_tf_reg <= {`CHB_TF_W{1'b0}};
            if (s_attr)
                access_space <= `CHB_SPACE_ATTR;
            else if (mode_is_io)
                access_space <= `CHB_SPACE_IO;
            else
                access_space <= `CHB_SPACE_COMMON;
        end
    end

    // ---------------------------------------------------------------
    // Data lanes
    // ---------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_data_out <= 16'h0000;
        end else if (mode_is_ata && !word_access) begin
            bus_data_out <= {8'h00, data_in[7:0]};
        end else begin
            bus_data_out <= data_in;
        end
    end

    // ---------------------------------------------------------------
    // Settling after reset
    // ---------------------------------------------------------------
    // The edge detector stays blind until the synchroniser and the
    // previous-value flops hold real pin samples; otherwise a pin that
    // sits high through reset would raise a false alert.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            settle <= 2'h0;
        else if (!settled)
            settle <= settle + 2'h1;
    end
    assign settled = (settle == `CHB_SETTLE_DONE);

    // ---------------------------------------------------------------
    // Status change alert
    // ---------------------------------------------------------------
    assign change = settled && ((s_ready != prev_ready) || (s_wp != prev_wp));

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ready            <= 1'b0;
            prev_wp               <= 1'b0;
            status_change_pending <= 1'b0;
        end else begin
            prev_ready <= s_ready;
            prev_wp    <= s_wp;
            // A new change in the acknowledge cycle keeps the flag set.
            if (mode_is_io && change)
                status_change_pending <= 1'b1;
            else if (alert_ack || !mode_is_io)
                status_change_pending <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Input acknowledge
    // ---------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            ack <= 1'b0;
        else
            ack <= mode_is_io && s_sel && s_iord && !s_attr;
    end
    assign input_acknowledge = ~ack;

    // ---------------------------------------------------------------
    // Multi-function pins 45 and 46
    // ---------------------------------------------------------------
    assign battery_detect_one = mode_is_mem ? 1'b1 :
                                mode_is_io  ? ~(alert_enable & status_change_pending) :
                                1'b0;
    assign battery_detect_two = mode_is_io ? 1'b1 : ~mode_is_ata;
    assign battery_detect_one_oe_n = mode_is_ata ? ~diag_drive_low : 1'b0;
    assign battery_detect_two_oe_n = mode_is_ata ? ~active_drive_low : 1'b0;
    assign pass_diagnostic_seen   = mode_is_ata & s_diag_low;
    assign secondary_present_seen = mode_is_ata & s_active_low;
endmodule

// *** tb/chb_host_bus_properties.sv ***
`timescale 1ns/1ps
`include "chb_defs.vh"
module chb_host_bus_properties (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        attr_sel_n,
    input wire logic        card_sel_n,
    input wire logic        io_read_n,
    input wire logic        alert_enable,
    input wire logic        status_change_pending,
    input wire logic        input_acknowledge,
    input wire logic        diag_drive_low,
    input wire logic        active_drive_low,
    input wire logic        battery_detect_one,
    input wire logic        battery_detect_two,
    input wire logic        battery_detect_one_oe_n,
    input wire logic        battery_detect_two_oe_n,
    input wire logic [1:0]  card_mode,
    input wire logic [10:0] addr,
    input wire logic [2:0]  access_tf_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    mem_detect_high_a: assert property (card_mode == `CHB_MODE_MEM |->
        battery_detect_one && battery_detect_two && !battery_detect_one_oe_n && !battery_detect_two_oe_n)
        else $error("battery detect not high");
    audio_neg_a: assert property (card_mode == `CHB_MODE_IO |->
        battery_detect_two || battery_detect_two_oe_n) else $error("audio output asserted");
    alert_low_a: assert property (card_mode == `CHB_MODE_IO && alert_enable && status_change_pending |->
        !battery_detect_one && !battery_detect_one_oe_n) else $error("status alert not driven low");
    alert_mask_a: assert property (card_mode == `CHB_MODE_IO && !alert_enable |->
        battery_detect_one || battery_detect_one_oe_n) else $error("masked status alert asserted");
    ack_io_a: assert property ((card_mode == `CHB_MODE_IO && !card_sel_n && !io_read_n && attr_sel_n) [*5]
        |-> !input_acknowledge) else $error("input acknowledge missing on read");
    ack_cause_a: assert property ($fell(input_acknowledge) |-> $past(card_mode == `CHB_MODE_IO) &&
        $past(!card_sel_n && !io_read_n && attr_sel_n, 3)) else $error("input acknowledge without read");
    ack_mem_a: assert property ((card_mode != `CHB_MODE_IO) [*5] |-> input_acknowledge)
        else $error("input acknowledge outside io mode");
    tf_decode_a: assert property ((card_mode == `CHB_MODE_ATA && $stable(addr)) [*5] |->
        access_tf_reg == addr[2:0]) else $error("task file index wrong");
    diag_drive_a: assert property ((card_mode == `CHB_MODE_ATA && diag_drive_low) [*3] |->
        !battery_detect_one_oe_n && !battery_detect_one) else $error("diagnostic line not pulled");
    active_drive_a: assert property ((card_mode == `CHB_MODE_ATA && active_drive_low) [*3] |->
        !battery_detect_two_oe_n && !battery_detect_two) else $error("active line not pulled");
endmodule
bind chb_host_bus chb_host_bus_properties i_chk (.*);

// *** tb/chb_host_model.sv ***
`timescale 1ns/1ps
module chb_host_model (
    input wire logic        ref_clk,
    input wire logic        ack_n,
    input wire logic        pd_val,
    input wire logic        pd_oe_n,
    input wire logic        act_val,
    input wire logic        act_oe_n,
    input wire logic        host_pd,
    input wire logic        host_act,
    input wire logic [1:0]  mode,
    input wire logic [10:0] addr_req,
    input wire logic [15:0] card_data,
    output logic [10:0]     addr,
    output logic [15:0]     rd_data,
    output logic            pd_line,
    output logic            act_line
);
    // ---------------------------------------------------------------
    // Host side of the pins
    // ---------------------------------------------------------------
    assign addr = (mode == 2'h2) ? {8'h00, addr_req[2:0]} : addr_req;
    // Buffer opens only under acknowledge, so stale bus data never lands.
    always @(posedge ref_clk) if (!ack_n) rd_data <= card_data;
    // Lines are pulled up; either party may pull them low.
    assign pd_line = !pd_oe_n ? pd_val & !host_pd : !host_pd;
    assign act_line = !act_oe_n ? act_val & !host_act : !host_act;
endmodule

// *** tb/chb_host_bus_tb.sv ***
`timescale 1ns/1ps
`include "chb_defs.vh"
module chb_host_bus_tb;
    logic        ref_clk = 0, rst_n = 0, attr_sel_n = 1, card_sel_n = 0, io_read_n = 1, card_ready = 0;
    logic        write_protect = 0, alert_enable = 0, alert_ack = 0, word_access = 0, diag_drive_low = 0;
    logic        host_pd = 0, host_act = 0, active_drive_low = 0;
    logic [1:0]  card_mode = 0;
    logic [10:0] addr_req = 0;
    logic [15:0] data_in = 0, r;
    wire         pend, ack, bd1, bd2, oe1, oe2, pd_l, act_l, pd_s, sp_s;
    wire  [1:0]  sp;
    wire  [2:0]  tf;
    wire  [10:0] addr, idx;
    wire  [15:0] dout, rd;
    int          fails = 0, compares = 0, i;
    // Row layout: mode, attribute select, expected space, address.
    logic [15:0] rows [6] = '{16'h2123, 16'h0FFE, 16'h73F7, 16'hBFF5, 16'hB802, 16'hB807};
    always #20 ref_clk = ~ref_clk;
    chb_host_bus i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .card_mode(card_mode), .addr(addr),
        .attr_sel_n(attr_sel_n), .card_sel_n(card_sel_n), .io_read_n(io_read_n), .card_ready(card_ready),
        .write_protect(write_protect), .alert_enable(alert_enable), .alert_ack(alert_ack),
        .status_change_pending(pend), .access_space(sp), .access_index(idx), .access_tf_reg(tf),
        .data_in(data_in), .word_access(word_access), .bus_data_out(dout), .input_acknowledge(ack),
        .battery_detect_one(bd1), .battery_detect_two(bd2),
        .battery_detect_one_oe_n(oe1), .battery_detect_two_oe_n(oe2),
        .diag_drive_low(diag_drive_low), .active_drive_low(active_drive_low), .pass_diagnostic_line_in(pd_l),
        .drive_active_secondary_present_in(act_l), .pass_diagnostic_seen(pd_s), .secondary_present_seen(sp_s));
    chb_host_model i_host (.ref_clk(ref_clk), .ack_n(ack), .pd_val(bd1), .pd_oe_n(oe1), .act_val(bd2),
        .act_oe_n(oe2), .host_pd(host_pd), .host_act(host_act), .mode(card_mode), .addr_req(addr_req),
        .card_data(dout), .addr(addr), .rd_data(rd), .pd_line(pd_l), .act_line(act_l));
    task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
        compares++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // A hang stops at 1000 cycles, well past the hundred or so cycles the tests need.
    initial begin
        #40000;
        fails++;
        end_sim;
    end
    initial begin
        w(20);
        chk(ack, 1, "ack_rst");
        chk(pend, 0, "pend_rst");
        rst_n = 1;
        w(3);
        for (i = 0; i < 6; i++) begin
            r = rows[i];
            card_mode = r[15:14];
            attr_sel_n = r[13];
            addr_req = r[10:0];
            io_read_n = !(r[15:14] == `CHB_MODE_IO);
            w(6);
            chk(sp, r[12:11], "space");
            if (r[15:14] == `CHB_MODE_ATA) chk(tf, r[2:0], "tf_reg");
            else chk(idx, r[10:0], "index");
        end
        card_mode = `CHB_MODE_IO;
        attr_sel_n = 1;
        io_read_n = 0;
        word_access = 1;
        data_in = 16'hA55A;
        w(6);
        chk(ack, 0, "ack_io");
        chk(rd, 16'hA55A, "read_word");
        chk(dout[7:0], 8'h5A, "even_byte");
        chk(dout[15:8], 8'hA5, "odd_byte");
        card_sel_n = 1;
        w(6);
        chk(ack, 1, "ack_unsel");
        card_sel_n = 0;
        card_mode = `CHB_MODE_MEM;
        w(6);
        chk(ack, 1, "ack_mem");
        chk({bd1, bd2}, 2'h3, "detect_mem");
        card_mode = `CHB_MODE_IO;
        io_read_n = 1;
        alert_enable = 1;
        w(2);
        card_ready = 1;
        w(5);
        chk(pend, 1, "pending");
        chk(bd1, 0, "alert_low");
        alert_ack = 1;
        w(1);
        chk(pend, 0, "pend_ack");
        alert_ack = 0;
        alert_enable = 0;
        write_protect = 1;
        w(5);
        chk(bd1, 1, "alert_mask");
        chk(bd2, 1, "audio");
        // Mid-run reset with both status pins high: no false alert after it.
        rst_n = 0;
        w(2);
        chk(pend, 0, "pend_rst2");
        chk(ack, 1, "ack_rst2");
        rst_n = 1;
        w(6);
        chk(pend, 0, "pend_settle");
        card_mode = `CHB_MODE_ATA;
        word_access = 0;
        data_in = 16'h1234;
        w(3);
        chk(dout, 16'h0034, "tf_byte");
        word_access = 1;
        diag_drive_low = 1;
        host_act = 1;
        w(4);
        chk(dout, 16'h1234, "ata_word");
        chk({pd_l, pd_s, sp_s}, 3'h3, "diag_pins");
        diag_drive_low = 0;
        host_act = 0;
        active_drive_low = 1;
        w(4);
        chk({pd_l, pd_s, act_l, sp_s, oe1, oe2}, 6'h26, "active_pins");
        end_sim;
    end
endmodule
